// ### pdd_disconnect.sv
// Notes on behaviour
// - while ac current is below threshold, the port timer advances each tick.
// - timer reaching timeout switches port off and sets its disconnect fault bit.
// - current above threshold before expiry clears timer; port stays powered.
// - per-port ac sense enable bit in register 13h gates ac sensing.
// - ac sensing uses the same timeout selected in register 16h.
// - ac sensing gives one reset pulse per oscillator cycle, only if current high.
// - ac and dc timer resets are ored; either keeps the port powered.
// - oscillator valid only if it crosses low and high within each 250 ms.
// - missing oscillator with mask set sets supply event bit 1 and interrupts.
// - oscillator-missing flag only requests interrupt, never switches ports off.
// - missing oscillator makes ac-only ports expire through normal timer.
// - any reset (power-on, software, pin) sets the oscillator-missing flag.
// - after clearing, flag sets again only on invalid oscillator or reset.
// - dc low current advances timer, glitch filtered; recovery restarts from zero.
// - timeout selected by two-bit field, bits 1 and 0 of register 16h.
// - per-port dc sense enable bit in register 13h gates dc sensing.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module pdd_disconnect #(
  parameter int PORTS = 4,
  parameter longint OSC_WINDOW = pdd_pkg::OSC_WINDOW_CYC,
  parameter longint TICK_LEN = pdd_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // reference oscillator comparators (pin domain)
  input wire logic ac_ref_below_lo,
  input wire logic ac_ref_above_hi,
  // per-port analog sense results (pin domain)
  input wire logic [PORTS-1:0] ac_above_threshold,
  input wire logic [PORTS-1:0] dc_current_low,
  // port power
  input wire logic [PORTS-1:0] port_power_req,
  output logic [PORTS-1:0] port_power_on,
  // interrupt
  output logic irq
);
  initial begin
    if (PORTS < 1 || PORTS > 4) $error("PORTS must be 1 to 4");
    if (OSC_WINDOW < 2 || TICK_LEN < 1) $error("window and tick must be positive");
  end

  localparam int OW_W = $clog2(OSC_WINDOW + 1);
  localparam int TK_W = $clog2(TICK_LEN + 1);

  // input synchronisers, three stages
  logic [2:0] s_lo_r;
  logic [2:0] s_hi_r;
  logic [PORTS-1:0] s_ac1_r, s_ac2_r, s_ac3_r;
  logic [PORTS-1:0] s_dc1_r, s_dc2_r, s_dc3_r;
  logic lo_q_r, hi_q_r;
  logic [PORTS-1:0] ac_q_r, dc_q_r;

  // registers
  logic [7:0] discon_ctl_r;
  logic [7:0] timing_r;
  logic [7:0] supply_mask_r;
  logic [7:0] supply_evt_r;
  logic [7:0] fault_r;
  logic [PORTS-1:0] on_r;
  logic [7:0] rdata_r;

  // oscillator tracking
  logic [OW_W-1:0] win_cnt_r;
  logic saw_lo_r, saw_hi_r;
  logic osc_phase_r;
  logic [PORTS-1:0] ac_seen_r;
  logic [TK_W-1:0] tick_cnt_r;

  // decode
  logic wr_evt, wr_mask, wr_fault, wr_dctl, wr_tim, wr_rst, wr_on;
  logic rd_evt, rd_fault;
  logic soft_rst;
  logic tick;
  logic win_end;
  logic osc_bad;
  logic cycle_end;
  logic [9:0] limit;
  logic [PORTS-1:0] expire;
  logic [PORTS-1:0] ac_pulse;
  logic [PORTS-1:0] ac_en, dc_en;
  logic [7:0] fault_set;
  logic [7:0] evt_set;
  logic [7:0] rd_mux;

  assign wr_evt = reg_wr && (reg_addr == pdd_pkg::ADDR_SUPPLY_EVT);
  assign wr_mask = reg_wr && (reg_addr == pdd_pkg::ADDR_SUPPLY_MASK);
  assign wr_fault = reg_wr && (reg_addr == pdd_pkg::ADDR_FAULT);
  assign wr_dctl = reg_wr && (reg_addr == pdd_pkg::ADDR_DISCON_CTL);
  assign wr_tim = reg_wr && (reg_addr == pdd_pkg::ADDR_TIMING);
  assign wr_rst = reg_wr && (reg_addr == pdd_pkg::ADDR_RESET_CTL);
  assign wr_on = reg_wr && (reg_addr == pdd_pkg::ADDR_PORT_ON);
  assign rd_evt = reg_rd && (reg_addr == pdd_pkg::ADDR_SUPPLY_EVT);
  assign rd_fault = reg_rd && (reg_addr == pdd_pkg::ADDR_FAULT);
  assign soft_rst = wr_rst && reg_wdata[pdd_pkg::RESET_ALL_BIT];

  assign ac_en = discon_ctl_r[pdd_pkg::AC_EN_LSB +: PORTS];
  assign dc_en = discon_ctl_r[pdd_pkg::DC_EN_LSB +: PORTS];

  // one shared timeout for ac and dc sensing
  always_comb begin
    unique case (timing_r[1:0])
      2'b00: limit = pdd_pkg::DISCONNECT_TIMEOUT_TICKS_0;
      2'b01: limit = pdd_pkg::DISCONNECT_TIMEOUT_TICKS_1;
      2'b10: limit = pdd_pkg::DISCONNECT_TIMEOUT_TICKS_2;
      2'b11: limit = pdd_pkg::DISCONNECT_TIMEOUT_TICKS_3;
    endcase
  end

  assign tick = (tick_cnt_r == TK_W'(TICK_LEN - 1));
  assign win_end = (win_cnt_r == OW_W'(OSC_WINDOW - 1));
  assign osc_bad = win_end && !(saw_lo_r && saw_hi_r);
  // an oscillator cycle ends on each low-to-high crossing
  assign cycle_end = osc_phase_r && hi_q_r && !lo_q_r;
  // no oscillator means no pulses, so ac-only ports time out
  assign ac_pulse = cycle_end ? (ac_seen_r | ac_q_r) : '0;

  assign fault_set = 8'(expire) << pdd_pkg::FAULT_DIS_LSB;
  assign evt_set = (osc_bad && supply_mask_r[pdd_pkg::OSC_MISSING_BIT])
                   ? (8'h01 << pdd_pkg::OSC_MISSING_BIT) : 8'h00;

  assign rd_mux = (reg_addr == pdd_pkg::ADDR_SUPPLY_EVT) ? supply_evt_r :
                  (reg_addr == pdd_pkg::ADDR_SUPPLY_MASK) ? supply_mask_r :
                  (reg_addr == pdd_pkg::ADDR_FAULT) ? fault_r :
                  (reg_addr == pdd_pkg::ADDR_DISCON_CTL) ? discon_ctl_r :
                  (reg_addr == pdd_pkg::ADDR_TIMING) ? timing_r :
                  (reg_addr == pdd_pkg::ADDR_PORT_ON) ? 8'(on_r) : 8'h00;

  assign reg_rdata = rdata_r;
  assign port_power_on = on_r;
  // osc flag only drives the interrupt
  assign irq = |(supply_evt_r & supply_mask_r) || |fault_r;

  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      pdd_port_timer #(
        .TW(10)
      ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .soft_rst(soft_rst),
        .power_on(on_r[g]),
        .tick(tick),
        .limit(limit),
        .ac_en(ac_en[g]),
        .dc_en(dc_en[g]),
        .ac_keep_pulse(ac_pulse[g]),
        .dc_low(dc_q_r[g]),
        .expire(expire[g])
      );
    end
  endgenerate

  // synchronisers; change accepted when stages two and three agree
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_lo_r <= 3'h0;
      s_hi_r <= 3'h0;
      s_ac1_r <= '0;
      s_ac2_r <= '0;
      s_ac3_r <= '0;
      s_dc1_r <= '0;
      s_dc2_r <= '0;
      s_dc3_r <= '0;
    end else begin
      s_lo_r <= {s_lo_r[1:0], ac_ref_below_lo};
      s_hi_r <= {s_hi_r[1:0], ac_ref_above_hi};
      s_ac1_r <= ac_above_threshold;
      s_ac2_r <= s_ac1_r;
      s_ac3_r <= s_ac2_r;
      s_dc1_r <= dc_current_low;
      s_dc2_r <= s_dc1_r;
      s_dc3_r <= s_dc2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lo_q_r <= 1'b0;
      hi_q_r <= 1'b0;
      ac_q_r <= '0;
      dc_q_r <= '0;
    end else begin
      if (s_lo_r[1] == s_lo_r[2]) lo_q_r <= s_lo_r[2];
      if (s_hi_r[1] == s_hi_r[2]) hi_q_r <= s_hi_r[2];
      ac_q_r <= (s_ac2_r & s_ac3_r) | (ac_q_r & (s_ac2_r | s_ac3_r));
      dc_q_r <= (s_dc2_r & s_dc3_r) | (dc_q_r & (s_dc2_r | s_dc3_r));
    end
  end

  // tick prescaler and oscillator window
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      win_cnt_r <= '0;
      saw_lo_r <= 1'b0;
      saw_hi_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TK_W'(1);
      win_cnt_r <= (win_end || soft_rst) ? '0 : win_cnt_r + OW_W'(1);
      saw_lo_r <= (win_end || soft_rst) ? lo_q_r : (saw_lo_r | lo_q_r);
      saw_hi_r <= (win_end || soft_rst) ? hi_q_r : (saw_hi_r | hi_q_r);
    end
  end

  // oscillator cycle tracking for ac pulses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      osc_phase_r <= 1'b0;
      ac_seen_r <= '0;
    end else begin
      if (lo_q_r) begin
        osc_phase_r <= 1'b1;
      end else if (cycle_end) begin
        osc_phase_r <= 1'b0;
      end
      ac_seen_r <= cycle_end ? '0 : (ac_seen_r | ac_q_r);
    end
  end

  // control registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      discon_ctl_r <= pdd_pkg::DISCON_CTL_RST;
      timing_r <= pdd_pkg::TIMING_RST;
      supply_mask_r <= pdd_pkg::SUPPLY_MASK_RST;
    end else if (soft_rst) begin
      discon_ctl_r <= pdd_pkg::DISCON_CTL_RST;
      timing_r <= pdd_pkg::TIMING_RST;
      supply_mask_r <= pdd_pkg::SUPPLY_MASK_RST;
    end else begin
      if (wr_dctl) discon_ctl_r <= reg_wdata;
      if (wr_tim) timing_r <= reg_wdata;
      if (wr_mask) supply_mask_r <= reg_wdata;
    end
  end

  // sticky status; hardware set wins over read clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      supply_evt_r <= pdd_pkg::SUPPLY_EVT_RST;
      fault_r <= 8'h00;
    end else if (soft_rst) begin
      supply_evt_r <= pdd_pkg::SUPPLY_EVT_RST;
      fault_r <= 8'h00;
    end else begin
      supply_evt_r <= ((rd_evt || wr_evt) ? 8'h00 : supply_evt_r) | evt_set;
      fault_r <= ((rd_fault || wr_fault) ? 8'h00 : fault_r) | fault_set;
    end
  end

  // port power switches
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      on_r <= '0;
    end else if (soft_rst) begin
      on_r <= '0;
    end else begin
      on_r <= (on_r | (wr_on ? reg_wdata[PORTS-1:0] & port_power_req : '0))
              & ~expire;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule

// ### pdd_disconnect_props.sv
`timescale 1ns/1ps
module pdd_disconnect_chk #(
  parameter int PORTS = 4,
  parameter longint TICK_LEN = pdd_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // port side
  input wire logic [PORTS-1:0] dc_current_low,
  input wire logic [PORTS-1:0] port_power_req,
  input wire logic [PORTS-1:0] port_power_on,
  input wire logic irq
);
  localparam longint MIN_OFF = 74 * TICK_LEN;
  wire on_wr = reg_wr && reg_addr == pdd_pkg::ADDR_PORT_ON;
  wire soft_wr = reg_wr && reg_addr == pdd_pkg::ADDR_RESET_CTL
                 && reg_wdata[pdd_pkg::RESET_ALL_BIT];
  logic [3:0] on_wr_d;
  logic [3:0] soft_d;
  logic [15:0] low_cnt;
  // cycles port 0 has been on without dc current
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      on_wr_d <= 4'h0;
      soft_d <= 4'h0;
      low_cnt <= 16'h0000;
    end else begin
      on_wr_d <= {on_wr_d[2:0], on_wr};
      soft_d <= {soft_d[2:0], soft_wr};
      low_cnt <= (!port_power_on[0] || !dc_current_low[0]) ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_dc_held;
    (!dc_current_low[0]) [*8] ##0 port_power_on[0];
  endsequence
  sequence s_disc;
    $fell(port_power_on[0]) ##0 port_power_req[0] ##0 (soft_d == 4'h0);
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 5'h1F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_power_by_write: assert property ($rose(port_power_on[0]) |-> on_wr_d != 4'h0)
    else $error("port switched on without write");
  a_reset_flag_irq: assert property ($rose(resetn) |-> irq [*2])
    else $error("irq low after reset");
  a_soft_reset: assert property (soft_wr |-> ##[1:2] (irq && port_power_on == '0))
    else $error("software reset state wrong");
  a_disc_fault_irq: assert property (s_disc |-> ##[0:2] irq)
    else $error("disconnect without irq");
  a_min_timeout: assert property (s_disc |-> low_cnt >= MIN_OFF)
    else $error("port off before timeout");
  a_dc_keeps: assert property (s_dc_held |=> port_power_on[0] || soft_d != 4'h0)
    else $error("port off while dc current present");
endmodule
bind pdd_disconnect pdd_disconnect_chk #(.PORTS(PORTS), .TICK_LEN(TICK_LEN)) i_chk (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dc_current_low(dc_current_low),
  .port_power_req(port_power_req), .port_power_on(port_power_on), .irq(irq));

// ### pdd_pkg.sv
package pdd_pkg;
  // register offsets (plain register port, 8-bit registers)
  localparam logic [4:0] ADDR_SUPPLY_EVT = 5'h0A;
  localparam logic [4:0] ADDR_SUPPLY_MASK = 5'h0B;
  localparam logic [4:0] ADDR_FAULT = 5'h06;
  localparam logic [4:0] ADDR_PORT_ON = 5'h19;
  localparam logic [4:0] ADDR_DISCON_CTL = 5'h13;
  localparam logic [4:0] ADDR_TIMING = 5'h16;
  localparam logic [4:0] ADDR_RESET_CTL = 5'h1A;
  // field positions
  localparam int OSC_MISSING_BIT = 1;
  localparam int DC_EN_LSB = 0;
  localparam int AC_EN_LSB = 4;
  localparam int FAULT_DIS_LSB = 4;
  localparam int RESET_ALL_BIT = 7;
  // reset values
  localparam logic [7:0] DISCON_CTL_RST = 8'hFF;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] SUPPLY_MASK_RST = 8'h02;
  localparam logic [7:0] SUPPLY_EVT_RST = 8'h02;
  // timing
  localparam longint CLK_HZ = 200000000;
  localparam longint TICK_US = 1000;
  localparam longint TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam longint OSC_WINDOW_MS = 250;
  localparam longint OSC_WINDOW_CYC = CLK_HZ / 1000 * OSC_WINDOW_MS;
  localparam int GLITCH_CYC = 4;
  // disconnect timeout in ticks per two-bit selection
  localparam logic [9:0] DISCONNECT_TIMEOUT_TICKS_0 = 10'h12C;
  localparam logic [9:0] DISCONNECT_TIMEOUT_TICKS_1 = 10'h4B;
  localparam logic [9:0] DISCONNECT_TIMEOUT_TICKS_2 = 10'h96;
  localparam logic [9:0] DISCONNECT_TIMEOUT_TICKS_3 = 10'h258;
endpackage

// ### pdd_port_model.sv
`timescale 1ns/1ps
module pdd_port_model (
  // clock and control
  input wire logic clk_sys,
  input wire logic osc_run,
  input wire logic [3:0] ac_pd,
  input wire logic [3:0] dc_pd,
  // port side
  input wire logic [3:0] port_power_on,
  output logic ac_ref_below_lo,
  output logic ac_ref_above_hi,
  output logic [3:0] ac_above_threshold,
  output logic [3:0] dc_current_low
);
  logic [5:0] phase_r = 6'h00;
  always_ff @(posedge clk_sys) begin
    phase_r <= (phase_r == 6'h27) ? 6'h00 : phase_r + 6'h01;
  end
  // stopped reference rests mid-scale, neither level crossed
  assign ac_ref_below_lo = osc_run && phase_r < 6'h0A;
  assign ac_ref_above_hi = osc_run && phase_r >= 6'h14 && phase_r < 6'h1E;
  // a load draws current only while switched on
  assign ac_above_threshold = port_power_on & ac_pd;
  assign dc_current_low = ~(port_power_on & dc_pd);
endmodule

// ### pdd_port_timer.sv
`timescale 1ns/1ps
module pdd_port_timer #(
  parameter int TW = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic soft_rst,
  // port status
  input wire logic power_on,
  input wire logic tick,
  input wire logic [TW-1:0] limit,
  // sensing
  input wire logic ac_en,
  input wire logic dc_en,
  input wire logic ac_keep_pulse,
  input wire logic dc_low,
  // result
  output logic expire
);
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;
  logic [2:0] glitch_r;
  logic dc_keep;
  logic keep;
  logic at_limit;

  // dc low must persist a few cycles before counting
  assign dc_keep = dc_en && !(dc_low && (glitch_r == 3'h7));
  assign keep = (ac_en && ac_keep_pulse) || dc_keep;
  assign at_limit = (cnt_r >= limit);
  assign expire = power_on && at_limit && tick && !keep;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!power_on || soft_rst) begin
      cnt_nxt = '0;
    end else if (keep) begin
      cnt_nxt = '0;
    end else if (tick && !at_limit) begin
      cnt_nxt = cnt_r + TW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      glitch_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
      glitch_r <= dc_low ? {glitch_r[1:0], 1'b1} : 3'h0;
    end
  end
endmodule

// ### test_pdd_disconnect.sv
`timescale 1ns/1ps
module test_pdd_disconnect;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] port_power_req = 4'h0;
  logic osc_run = 1'b1;
  logic [3:0] ac_pd = 4'h0;
  logic [3:0] dc_pd = 4'h0;
  logic [7:0] reg_rdata;
  logic ref_lo;
  logic ref_hi;
  logic [3:0] ac_hi;
  logic [3:0] dc_lo;
  logic [3:0] pon;
  logic irq;
  logic [9:0] tk [4] = '{pdd_pkg::DISCONNECT_TIMEOUT_TICKS_0, pdd_pkg::DISCONNECT_TIMEOUT_TICKS_1,
    pdd_pkg::DISCONNECT_TIMEOUT_TICKS_2, pdd_pkg::DISCONNECT_TIMEOUT_TICKS_3};
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  pdd_disconnect #(.OSC_WINDOW(200), .TICK_LEN(4)) i_dut (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ac_ref_below_lo(ref_lo),
    .ac_ref_above_hi(ref_hi), .ac_above_threshold(ac_hi), .dc_current_low(dc_lo),
    .port_power_req(port_power_req), .port_power_on(pon), .irq(irq));
  pdd_port_model i_pd (.clk_sys(clk_sys), .osc_run(osc_run), .ac_pd(ac_pd), .dc_pd(dc_pd),
    .port_power_on(pon), .ac_ref_below_lo(ref_lo), .ac_ref_above_hi(ref_hi),
    .ac_above_threshold(ac_hi), .dc_current_low(dc_lo));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, $sformatf("reg %h", a));
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    // let outputs launched at this edge settle before any compare
    #1;
  endtask
  task automatic complete_run;
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    idle(6);
    resetn <= 1'b1;
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h02);
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h00);
    rd(pdd_pkg::ADDR_SUPPLY_MASK, pdd_pkg::SUPPLY_MASK_RST);
    rd(pdd_pkg::ADDR_DISCON_CTL, pdd_pkg::DISCON_CTL_RST);
    rd(pdd_pkg::ADDR_TIMING, pdd_pkg::TIMING_RST);
    rd(5'h1F, 8'h00);
    // port 0 ac load, port 1 dc load, port 2 none, port 3 both
    ac_pd <= 4'h9;
    dc_pd <= 4'hA;
    port_power_req <= 4'hF;
    wr(pdd_pkg::ADDR_PORT_ON, 8'h0B);
    for (int i = 0; i < 4; i++) begin
      wr(pdd_pkg::ADDR_TIMING, 8'(i));
      rd(pdd_pkg::ADDR_TIMING, 8'(i));
      wr(pdd_pkg::ADDR_PORT_ON, 8'h04);
      idle(int'(tk[i]) * 4 - 20);
      chk({4'h0, pon}, 8'h0F, "ports before timeout");
      idle(60);
      chk({4'h0, pon}, 8'h0B, "ports after timeout");
      chk({7'h00, irq}, 8'h01, "irq on fault");
      rd(pdd_pkg::ADDR_FAULT, 8'h40);
    end
    wr(pdd_pkg::ADDR_TIMING, 8'h01);
    wr(pdd_pkg::ADDR_DISCON_CTL, 8'hED);
    idle(400);
    chk({4'h0, pon}, 8'h08, "ports sense disabled");
    rd(pdd_pkg::ADDR_FAULT, 8'h30);
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h00);
    wr(pdd_pkg::ADDR_DISCON_CTL, 8'hF1);
    ac_pd <= 4'hF;
    dc_pd <= 4'hF;
    wr(pdd_pkg::ADDR_PORT_ON, 8'h09);
    osc_run <= 1'b0;
    idle(400);
    chk({4'h0, pon}, 8'h01, "ports osc missing");
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h02);
    rd(pdd_pkg::ADDR_FAULT, 8'h80);
    wr(pdd_pkg::ADDR_SUPPLY_MASK, 8'h00);
    wr(pdd_pkg::ADDR_SUPPLY_EVT, 8'h00);
    idle(450);
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h00);
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(pdd_pkg::ADDR_SUPPLY_MASK, 8'h02);
    idle(450);
    chk({7'h00, irq}, 8'h01, "irq osc missing");
    wr(pdd_pkg::ADDR_RESET_CTL, 8'h80);
    idle(2);
    chk({4'h0, pon}, 8'h00, "ports soft reset");
    rd(pdd_pkg::ADDR_SUPPLY_EVT, 8'h02);
    rd(pdd_pkg::ADDR_DISCON_CTL, pdd_pkg::DISCON_CTL_RST);
    complete_run();
  end
endmodule
